/* pwdt_consts.vh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * protected watchdog timer.
 * Assumes a simple byte-wide register port decoding low address bits.
 */
`ifndef PWDT_CONSTS_VH
`define PWDT_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define PWDT_ADDR_W          2
`define PWDT_OFF_CTRL        2'h0
`define PWDT_OFF_COUNT       2'h1
`define PWDT_OFF_MODE        2'h2

// ****************************************
// Control/status field positions
// ****************************************
`define PWDT_B_CNT_WI        7
`define PWDT_B_CNT_WE        6
`define PWDT_B_CTL_WI        5
`define PWDT_B_CTL_WE        4
`define PWDT_B_RUN_WI        3
`define PWDT_B_RUN           2
`define PWDT_B_RST_WI        1
`define PWDT_B_RST_FLAG      0

// ****************************************
// Reset values
// ****************************************
`define PWDT_COUNT_RST       8'h00
`define PWDT_CKS_RST         4'hF
`define PWDT_MODE_UPPER      4'hF

// ****************************************
// Timing counts
// ****************************************
`define PWDT_RST_HOLD_OSC    512
`define PWDT_SUB_DIV         32
`define PWDT_FIXED_DIV_LOG2  13
`define PWDT_MIN_DIV_LOG2    6

`endif

/* pwdt_sync.v */
/*
 * Three-flop synchroniser with rising-edge pulse output.
 * Assumes the input is a slow level from another clock domain.
 */
`timescale 1ns/100ps

module pwdt_sync (
  // Clock and reset
  input  wire  clk_i,
  input  wire  srst_i,
  // Asynchronous level in
  input  wire  async_i,
  // Synchronised level and rising-edge pulse
  output wire  level_o,
  output wire  rise_o
);

  reg  [2:0]  stage;
  reg         level_q;

  // First stage feeds only the second; second and third must agree
  always @(posedge clk_i) begin
    if (srst_i) begin
      stage <= 3'h0;
    end else begin
      stage <= {stage[1:0], async_i};
    end
  end

  // Agreed level out; rise counts once stages two and three agree high
  assign level_o = level_q;
  assign rise_o  = stage[1] & stage[2] & ~level_q;

  // Remembers the last agreed level
  always @(posedge clk_i) begin
    if (srst_i) begin
      level_q <= 1'b0;
    end else if (stage[1] == stage[2]) begin
      level_q <= stage[2];
    end
  end

endmodule

/* pwdt_top.v */
/*
 * Protected watchdog timer: 8-bit up counter, write-protected control and
 * status register, clock mode register and internal reset request.
 * Assumes the subclock and on-chip oscillator arrive as slow clocks that
 * are sampled here, and software uses whole-byte register writes.
 * Both clock sources must stay well below half the system clock rate,
 * since each level passes three flops before an edge is counted.
 * The reset request is not fed back here: only the pin reset or a software
 * clear resets the reset flag, so the flag survives the reset that it reports.
 */
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "pwdt_consts.vh"

module pwdt_top #(
  parameter        RUN_RESET_VAL = 1'b1,   // Run bit value after pin reset
  parameter        HAS_MODE_REG  = 1,      // 1: mode register present
  parameter        RST_HOLD_OSC  = `PWDT_RST_HOLD_OSC
) (
  // Clock and pin reset
  input  wire                    clk_i,
  input  wire                    srst_i,
  // Register port
  input  wire [`PWDT_ADDR_W-1:0] reg_addr_i,
  input  wire [7:0]              reg_wdata_i,
  input  wire                    reg_wr_i,
  input  wire                    reg_rd_i,
  output reg  [7:0]              reg_rdata_o,
  // Clock sources and override
  input  wire                    subclk_i,
  input  wire                    osc_clk_i,
  input  wire                    watchdog_clock_override_i,
  // Internal reset request
  output reg                     wdt_reset_req_o
);

  // ****************************************
  // Registers
  // ****************************************
  reg         counter_write_enable;
  reg         control_write_enable;
  reg         watchdog_run;
  reg         watchdog_reset_flag;
  reg  [7:0]  wdt_counter;
  reg  [3:0]  clock_select;
  reg  [12:0] presc;
  reg  [4:0]  sub_div;
  reg  [9:0]  hold_cnt;
  reg         override_q;

  wire        sub_rise;
  wire        osc_rise;
  wire        override_lvl;

  wire wr_ctrl  = reg_wr_i & (reg_addr_i == `PWDT_OFF_CTRL);
  wire wr_count = reg_wr_i & (reg_addr_i == `PWDT_OFF_COUNT);
  wire wr_mode  = reg_wr_i & (reg_addr_i == `PWDT_OFF_MODE);

  // ****************************************
  // Clock source crossing
  // ****************************************

  // Subclock edges into the system domain
  pwdt_sync u_sub_sync (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .async_i (subclk_i),
    .level_o (),
    .rise_o  (sub_rise)
  );

  // Oscillator edges into the system domain
  pwdt_sync u_osc_sync (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .async_i (osc_clk_i),
    .level_o (),
    .rise_o  (osc_rise)
  );

  // Override pin level
  pwdt_sync u_ovr_sync (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .async_i (watchdog_clock_override_i),
    .level_o (override_lvl),
    .rise_o  ()
  );

  // Agreed override level from stages two and three
  always @(posedge clk_i) begin
    if (srst_i) begin
      override_q <= 1'b0;
    end else begin
      override_q <= override_lvl;
    end
  end

  // Free-running system clock prescaler; run does not clear it, so the
  // first tick after a run start may come early
  always @(posedge clk_i) begin
    if (srst_i) begin
      presc <= 13'h0000;
    end else begin
      presc <= presc + 13'h0001;
    end
  end

  // Subclock divide by 32
  always @(posedge clk_i) begin
    if (srst_i) begin
      sub_div <= 5'h00;
    end else if (sub_rise) begin
      sub_div <= sub_div + 5'h01;
    end
  end

  wire sub_tick = sub_rise & (sub_div == 5'h1F);

  // ****************************************
  // Count tick selection
  // ****************************************

  // Prescaler tap for divide by 2^(6+n); mask has the low bits set
  wire [3:0]  tap_n    = HAS_MODE_REG ? {1'b0, clock_select[2:0]}
                                      : 4'h7;
  // One bit wider so the divide-by-8192 mask does not wrap
  wire [13:0] tap_span = (14'h0040 << tap_n) - 14'h0001;
  wire [12:0] tap_mask = tap_span[12:0];
  wire        sys_tick = ((presc & tap_mask) == tap_mask);

  // One-cycle increment enable from the selected source
  reg count_tick;
  always @* begin
    if (override_q) begin
      count_tick = sub_tick;
    end else if (HAS_MODE_REG == 0) begin
      count_tick = sys_tick;
    end else if (!clock_select[3]) begin
      count_tick = osc_rise;
    end else begin
      count_tick = sys_tick;
    end
  end

  // ****************************************
  // Counter and overflow
  // ****************************************
  // Software write this cycle; it beats the count, so no overflow either
  wire count_write = wr_count & counter_write_enable;
  wire overflow    = watchdog_run & count_tick & ~count_write &
                     (wdt_counter == 8'hFF);

  // Counter: write wins over count, wraps on overflow
  always @(posedge clk_i) begin
    if (srst_i) begin
      wdt_counter <= `PWDT_COUNT_RST;
    end else if (count_write) begin
      wdt_counter <= reg_wdata_i;
    end else if (watchdog_run && count_tick) begin
      wdt_counter <= wdt_counter + 8'h01;
    end
  end

  // ****************************************
  // Internal reset request
  // ****************************************

  // Last oscillator edge of the hold; request drops on it
  wire hold_done = wdt_reset_req_o & osc_rise & (hold_cnt == 10'h001);

  // Reset request held for a number of oscillator edges
  always @(posedge clk_i) begin
    if (srst_i) begin
      hold_cnt        <= 10'h000;
      wdt_reset_req_o <= 1'b0;
    end else if (overflow) begin
      hold_cnt        <= RST_HOLD_OSC[9:0];
      wdt_reset_req_o <= 1'b1;
    end else if (wdt_reset_req_o && osc_rise) begin
      hold_cnt        <= hold_cnt - 10'h001;
      if (hold_done) begin
        wdt_reset_req_o <= 1'b0;
      end
    end
  end

  // ****************************************
  // Control/status register
  // ****************************************

  // Enable flags; pin reset only
  always @(posedge clk_i) begin
    if (srst_i) begin
      counter_write_enable <= 1'b0;
      control_write_enable <= 1'b0;
    end else if (wr_ctrl) begin
      if (!reg_wdata_i[`PWDT_B_CNT_WI]) begin
        counter_write_enable <= reg_wdata_i[`PWDT_B_CNT_WE];
      end
      if (!reg_wdata_i[`PWDT_B_CTL_WI]) begin
        control_write_enable <= reg_wdata_i[`PWDT_B_CTL_WE];
      end
    end
  end

  // Run bit, gated by the enable already held
  always @(posedge clk_i) begin
    if (srst_i) begin
      watchdog_run <= RUN_RESET_VAL[0];
    end else if (wr_ctrl && control_write_enable &&
                 !reg_wdata_i[`PWDT_B_RUN_WI]) begin
      watchdog_run <= reg_wdata_i[`PWDT_B_RUN];
    end
  end

  // Reset flag: overflow set wins over software clear, so an overflow
  // that meets the clearing write is never lost
  always @(posedge clk_i) begin
    if (srst_i) begin
      watchdog_reset_flag <= 1'b0;
    end else if (overflow) begin
      watchdog_reset_flag <= 1'b1;
    end else if (wr_ctrl && control_write_enable &&
                 !reg_wdata_i[`PWDT_B_RST_WI] &&
                 !reg_wdata_i[`PWDT_B_RST_FLAG]) begin
      watchdog_reset_flag <= 1'b0;
    end
  end

  // ****************************************
  // Mode register
  // ****************************************

  // Clock select field; upper nibble not stored
  always @(posedge clk_i) begin
    if (srst_i) begin
      clock_select <= `PWDT_CKS_RST;
    end else if (wr_mode && HAS_MODE_REG != 0) begin
      clock_select <= reg_wdata_i[3:0];
    end
  end

  // ****************************************
  // Read data, one cycle after the strobe
  // ****************************************
  // Inhibit positions read as ones; they hold no state
  wire [7:0] ctrl_view = {1'b1, counter_write_enable,
                          1'b1, control_write_enable,
                          1'b1, watchdog_run,
                          1'b1, watchdog_reset_flag};

  // Read mux, zero for unmapped and absent registers
  reg [7:0] next_rdata;
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr_i)
      `PWDT_OFF_CTRL: begin
        next_rdata = ctrl_view;
      end
      `PWDT_OFF_COUNT: begin
        next_rdata = wdt_counter;
      end
      `PWDT_OFF_MODE: begin
        if (HAS_MODE_REG != 0) begin
          next_rdata = {`PWDT_MODE_UPPER, clock_select};
        end
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // Read data register
  always @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule

/* pwdt_asserts.sv */
/* Concurrent checks on the watchdog register port and reset request.
   Assumes the request hold spans 8 to 200 system clocks. */
`timescale 1ns/100ps
// ************************
// Port checker
// ************************
module pwdt_asserts (
  // Clock and reset
  input wire       clk_i,
  input wire       srst_i,
  // Register port and request
  input wire [1:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire       reg_wr_i,
  input wire       reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire       wdt_reset_req_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Read answers
  rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not idle");
  inhib_ones_a: assert property (
    reg_rd_i && reg_addr_i == 2'h0 |=> (reg_rdata_o & 8'hAA) == 8'hAA)
    else $error("inhibit bit read as zero");
  mode_upper_a: assert property (
    reg_rd_i && reg_addr_i == 2'h2 |=> reg_rdata_o[7:4] == 4'hF)
    else $error("mode upper nibble not ones");
  unmapped_zero_a: assert property (
    reg_rd_i && reg_addr_i == 2'h3 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  // Enable flags follow unlocked writes
  cnt_enable_a: assert property (
    (reg_wr_i && reg_addr_i == 2'h0 && !reg_wdata_i[7]) ##1
    (reg_rd_i && reg_addr_i == 2'h0) |=>
    reg_rdata_o[6] == $past(reg_wdata_i[6], 2))
    else $error("counter enable not written");
  ctl_enable_a: assert property (
    (reg_wr_i && reg_addr_i == 2'h0 && !reg_wdata_i[5]) ##1
    (reg_rd_i && reg_addr_i == 2'h0) |=>
    reg_rdata_o[4] == $past(reg_wdata_i[4], 2))
    else $error("control enable not written");
  // Reset request shape and flag
  req_hold_a: assert property (
    $rose(wdt_reset_req_o) |-> wdt_reset_req_o [*8])
    else $error("reset request too short");
  req_end_a: assert property (
    $rose(wdt_reset_req_o) |-> ##[1:200] !wdt_reset_req_o)
    else $error("reset request never ends");
  req_flag_a: assert property (
    wdt_reset_req_o && reg_rd_i && reg_addr_i == 2'h0 |=> reg_rdata_o[0])
    else $error("reset flag not set");
  rst_clear_a: assert property (
    $fell(srst_i) |-> !wdt_reset_req_o && reg_rdata_o == 8'h00)
    else $error("pin reset left outputs set");
endmodule

bind pwdt_top pwdt_asserts u_pwdt_chk (
  .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .wdt_reset_req_o(wdt_reset_req_o)
);

/* protected_watchdog_timer_bench.sv */
/* Self-checking bench for the protected watchdog timer.
   Assumes a 125 MHz clock, a free-running on-chip oscillator and
   a free-running subclock. */
`timescale 1ns/100ps
module protected_watchdog_timer_bench;
  // ************************
  // Stimulus and checks
  // ************************
  reg        clk_i        = 1'b0;
  reg        srst_i       = 1'b1;
  reg  [1:0] reg_addr_i   = 2'h0;
  reg  [7:0] reg_wdata_i  = 8'h00;
  reg        reg_wr_i     = 1'b0;
  reg        reg_rd_i     = 1'b0;
  reg        osc_clk_i    = 1'b0;
  reg        subclk_i     = 1'b0;
  reg        watchdog_clock_override_i = 1'b0;
  wire [7:0] reg_rdata_o;
  wire       wdt_reset_req_o;
  integer    n_errors     = 0;
  integer    total_checks = 0;
  integer    k;

  // System clock, unrelated oscillator and subclock
  always #4 clk_i = ~clk_i;
  always #37 osc_clk_i = ~osc_clk_i;
  always #21 subclk_i = ~subclk_i;

  // Short request hold keeps the run brief
  pwdt_top #(.RST_HOLD_OSC(4)) dut (
    .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .subclk_i(subclk_i), .osc_clk_i(osc_clk_i),
    .watchdog_clock_override_i(watchdog_clock_override_i),
    .wdt_reset_req_o(wdt_reset_req_o)
  );

  // Verdict and end of run
  task final_report;
    begin
      if (n_errors == 0 && total_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  // Compare one value
  task chk(input string n, input [7:0] seen, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("[ERR] %s expected %h seen %h", n, exp, seen);
      end
    end
  endtask

  // One write cycle, strobe left for the next task
  task wr(input [1:0] a, input [7:0] d);
    begin
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      reg_rd_i    <= 1'b0;
      @(posedge clk_i);
    end
  endtask

  // One read cycle, data taken in the answer cycle
  task rd(input [1:0] a, input [7:0] e, input string n);
    begin
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      reg_wr_i   <= 1'b0;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      @(posedge clk_i);
      chk(n, reg_rdata_o, e);
    end
  endtask

  // Idle bus for a span
  task idle(input integer n);
    begin
      reg_wr_i <= 1'b0;
      repeat (n) @(posedge clk_i);
    end
  endtask

  // Pin reset held six cycles
  task rst_pulse;
    begin
      repeat (6) @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask

  // Overflow must land in a window, flag seen, request released
  task ovf(input integer lo, input integer hi);
    integer   c;
    reg [7:0] hit;
    begin
      reg_wr_i <= 1'b0;
      c = 0;
      while (wdt_reset_req_o !== 1'b1 && c < hi) begin
        @(posedge clk_i);
        c = c + 1;
      end
      hit = {7'h00, wdt_reset_req_o === 1'b1 && c >= lo};
      chk("overflow time", hit, 8'h01);
      rd(2'h0, 8'hFF, "flag on overflow");
      c = 0;
      while (wdt_reset_req_o !== 1'b0 && c < 300) begin
        @(posedge clk_i);
        c = c + 1;
      end
      chk("request release", {7'h00, wdt_reset_req_o}, 8'h00);
    end
  endtask

  // Main sequence
  initial begin
    rst_pulse;
    rd(2'h0, 8'hAE, "ctrl reset");
    rd(2'h1, 8'h00, "count reset");
    rd(2'h2, 8'hFF, "mode reset");
    rd(2'h3, 8'h00, "unmapped");
    wr(2'h0, 8'hA2);
    rd(2'h0, 8'hAE, "run locked");
    wr(2'h1, 8'h55);
    rd(2'h1, 8'h00, "count locked");
    wr(2'h0, 8'hD0);
    rd(2'h0, 8'hBE, "ctl enable");
    wr(2'h0, 8'hA2);
    rd(2'h0, 8'hBA, "run off");
    wr(2'h0, 8'h5F);
    rd(2'h0, 8'hFA, "cnt enable");
    wr(2'h1, 8'h55);
    wr(2'h2, 8'h08);
    rd(2'h1, 8'h55, "count write");
    rd(2'h2, 8'hF8, "mode write");
    idle(200);
    rd(2'h1, 8'h55, "count hold");
    wr(2'h0, 8'hA6);
    for (k = 0; k < 8; k = k + 1) begin
      wr(2'h2, 8'h08 + k[7:0]);
      wr(2'h1, 8'hFE);
      ovf(64 << k, (128 << k) + 8);
    end
    wr(2'h0, 8'hA6);
    rd(2'h0, 8'hFF, "flag kept");
    wr(2'h0, 8'hA4);
    rd(2'h0, 8'hFE, "flag clear");
    wr(2'h2, 8'h07);
    wr(2'h1, 8'hFD);
    ovf(12, 50);
    watchdog_clock_override_i <= 1'b1;
    idle(8);
    wr(2'h1, 8'hFE);
    ovf(150, 350);
    srst_i <= 1'b1;
    rst_pulse;
    rd(2'h0, 8'hAE, "pin reset");
    final_report;
  end

  // Watchdog against a hung run
  initial begin
    repeat (60000) @(posedge clk_i);
    n_errors = n_errors + 1;
    final_report;
  end
endmodule
